//--- logic/cle_defines.vh
// Shared constants for the tile control list executer.
`ifndef CLE_DEFINES_VH
`define CLE_DEFINES_VH
`define REG_CT0_CUR 8'h00
`define REG_CT1_CUR 8'h04
`define REG_CT0_END 8'h08
`define REG_CT1_END 8'h0C
`define REG_CT0_CS 8'h10
`define REG_CT1_CS 8'h14
`define REG_BFC 8'h18
`define REG_RFC 8'h1C
`define REG_INT_EN 8'h20
`define REG_INT_ST 8'h24
`define REG_QRSV 8'h28
`define REG_PIPE_ST 8'h2C
`define CS_MK_MSB 7
`define CS_RUN 8
`define CS_SEMW 9
`define PS_BMODE 1:0
`define PS_RMODE 3:2
`define PS_COV 4
`define PS_SEM 15:8
`define IRQ_W 4
`define IRQ_RFRAME 0
`define IRQ_BFRAME 1
`define IRQ_OOM 2
`define IRQ_OVSP 3
`define OP_HALT 8'h00
`define OP_MARKER 8'h02
`define OP_FLUSH 8'h04
`define OP_FLUSH_ALL 8'h05
`define OP_START_BIN 8'h06
`define OP_SEM_INC 8'h07
`define OP_SEM_WAIT 8'h08
`define OP_BRANCH 8'h10
`define OP_CALL 8'h11
`define OP_RET 8'h12
`define OP_STORE_EOF 8'h19
`define OP_SH_GL 8'h40
`define OP_SH_NV 8'h41
`define OP_SH_VG 8'h42
`define OP_CONFIG 8'h60
`define CFG_COV_BIT 0
`define LEN_ADDR 3'h4
`define LEN_CFG 3'h1
`define VM_SHADED 2'h0
`define VM_PRESHADED 2'h1
`define VM_XY 2'h2
`define STACK_DEPTH 2'h2
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

//--- logic/list_fetcher.v
// One command-list thread: address walk, operand gathering and sub-list stack.
`timescale 1ns/1ps
`default_nettype none
`include "cle_defines.vh"
module list_fetcher (
    input wire clk,
    input wire srst,
    input wire cur_wr,
    input wire end_wr,
    input wire [31:0] wdata,
    input wire sem_grant,
    output reg [31:0] cur_addr,
    output reg [31:0] end_addr,
    output reg fetch_req,
    output reg [31:0] fetch_addr,
    input wire fetch_valid,
    input wire [7:0] fetch_data,
    output reg cmd_valid,
    output reg [7:0] cmd_op,
    output reg [31:0] cmd_arg,
    output wire sem_wait,
    output wire running
);
    localparam S_IDLE = 4'b0001;
    localparam S_FETCH = 4'b0010;
    localparam S_SEM = 4'b0100;
    localparam S_HALT = 4'b1000;
    reg [3:0] state;
    reg [2:0] left;
    reg [1:0] idx;
    reg [31:0] stack0;
    reg [31:0] stack1;
    reg [1:0] depth;
    reg [31:0] next_arg;
    wire [7:0] fin_op;
    wire fin;
    wire [31:0] ret_addr;

    function [2:0] arg_len;
        input [7:0] op;
        begin
            case (op)
                `OP_BRANCH, `OP_CALL, `OP_SH_GL, `OP_SH_NV, `OP_SH_VG: arg_len = `LEN_ADDR;
                `OP_CONFIG: arg_len = `LEN_CFG;
                default: arg_len = 3'h0;
            endcase
        end
    endfunction

    always @* begin
        next_arg = cmd_arg;
        next_arg[{idx, 3'b000} +: 8] = fetch_data;
    end

    assign fin_op = (left == 3'h0) ? fetch_data : cmd_op;
    assign fin = fetch_valid && ((left == 3'h0) ? (arg_len(fetch_data) == 3'h0) : (left == 3'h1));
    assign ret_addr = cur_addr + 32'h1;
    assign sem_wait = (state == S_SEM);
    assign running = (state != S_HALT) && (cur_addr != end_addr);

    always @(posedge clk) begin
        if (srst) begin
            state <= S_IDLE;
            cur_addr <= 32'h0;
            end_addr <= 32'h0;
            fetch_req <= 1'b0;
            fetch_addr <= 32'h0;
            cmd_valid <= 1'b0;
            cmd_op <= 8'h0;
            cmd_arg <= 32'h0;
            left <= 3'h0;
            idx <= 2'h0;
            stack0 <= 32'h0;
            stack1 <= 32'h0;
            depth <= 2'h0;
        end else begin
            cmd_valid <= 1'b0;
            if (end_wr) begin
                end_addr <= wdata;
            end
            case (state)
                S_IDLE: begin
                    // Only an exact match stops the walk, so a new end restarts it at once.
                    if (cur_addr != end_addr) begin
                        fetch_req <= 1'b1;
                        fetch_addr <= cur_addr;
                        state <= S_FETCH;
                    end
                end
                S_FETCH: begin
                    if (fetch_valid) begin
                        fetch_req <= 1'b0;
                        cur_addr <= ret_addr;
                        state <= S_IDLE;
                        if (left == 3'h0) begin
                            cmd_op <= fetch_data;
                            cmd_arg <= 32'h0;
                            idx <= 2'h0;
                            left <= arg_len(fetch_data);
                        end else begin
                            cmd_arg <= next_arg;
                            idx <= idx + 2'h1;
                            left <= left - 3'h1;
                        end
                        if (fin) begin
                            cmd_valid <= 1'b1;
                            case (fin_op)
                                `OP_BRANCH: cur_addr <= next_arg;
                                `OP_CALL: begin
                                    // A third level of nesting is not supported; the call is skipped.
                                    if (depth != `STACK_DEPTH) begin
                                        if (depth == 2'h0) begin
                                            stack0 <= ret_addr;
                                        end else begin
                                            stack1 <= ret_addr;
                                        end
                                        depth <= depth + 2'h1;
                                        cur_addr <= next_arg;
                                    end
                                end
                                `OP_RET: begin
                                    if (depth != 2'h0) begin
                                        cur_addr <= (depth == `STACK_DEPTH) ? stack1 : stack0;
                                        depth <= depth - 2'h1;
                                    end
                                end
                                `OP_HALT: state <= S_HALT;
                                `OP_SEM_WAIT: state <= S_SEM;
                                default: state <= S_IDLE;
                            endcase
                        end
                    end
                end
                S_SEM: begin
                    if (sem_grant) begin
                        state <= S_IDLE;
                    end
                end
                S_HALT: state <= S_HALT;
                default: state <= S_IDLE;
            endcase
            // The memory must not answer a fetch after the current address was rewritten.
            if (cur_wr) begin
                cur_addr <= wdata;
                depth <= 2'h0;
                left <= 3'h0;
                fetch_req <= 1'b0;
                state <= S_IDLE;
            end
        end
    end
endmodule
`default_nettype wire

//--- logic/batch_arbiter.v
// Per-batch fair sharing of the vertex fetch engine and vertex memory.
`timescale 1ns/1ps
`default_nettype none
`include "cle_defines.vh"
module batch_arbiter (
    input wire clk,
    input wire srst,
    input wire [1:0] batch_req,
    input wire [1:0] batch_done,
    input wire [1:0] bin_mode,
    input wire [1:0] ren_mode,
    output reg [1:0] batch_grant,
    output reg [1:0] xy_pass
);
    reg busy;
    reg owner;
    reg last;
    wire [1:0] elig;
    wire pick;

    assign elig = batch_req & {ren_mode != `VM_XY, bin_mode != `VM_XY};
    assign pick = (elig == 2'b11) ? ~last : elig[1];

    always @(posedge clk) begin
        if (srst) begin
            busy <= 1'b0;
            owner <= 1'b0;
            last <= 1'b1;
            batch_grant <= 2'b00;
            xy_pass <= 2'b00;
        end else begin
            batch_grant <= 2'b00;
            if (busy && batch_done[owner]) begin
                busy <= 1'b0;
            end else if (!busy && (elig != 2'b00)) begin
                // Alternating winners stops the faster pipe from filling vertex memory.
                busy <= 1'b1;
                owner <= pick;
                last <= pick;
                batch_grant <= pick ? 2'b10 : 2'b01;
            end
            // Direct primitives wait until their own pipe has no batch in flight.
            xy_pass[0] <= (bin_mode == `VM_XY) && !(busy && !owner);
            xy_pass[1] <= (ren_mode == `VM_XY) && !(busy && owner);
        end
    end
endmodule
`default_nettype wire

//--- logic/tile_control_list_executer.v
// Control list executer top: register slave, two threads, semaphores and pipe steering.
//
// Design decisions made here: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "cle_defines.vh"
module tile_control_list_executer (
    input wire clk,
    input wire srst,
    input wire [7:0] awaddr,
    input wire awvalid,
    output reg awready,
    input wire [31:0] wdata,
    input wire [3:0] wstrb,
    input wire wvalid,
    output reg wready,
    output reg [1:0] bresp,
    output reg bvalid,
    input wire bready,
    input wire [7:0] araddr,
    input wire arvalid,
    output reg arready,
    output reg [31:0] rdata,
    output reg [1:0] rresp,
    output reg rvalid,
    input wire rready,
    output wire bin_fetch_req,
    output wire [31:0] bin_fetch_addr,
    input wire bin_fetch_valid,
    input wire [7:0] bin_fetch_data,
    output wire ren_fetch_req,
    output wire [31:0] ren_fetch_addr,
    input wire ren_fetch_valid,
    input wire [7:0] ren_fetch_data,
    output reg tile_binner_start,
    output reg tile_binner_flush,
    output reg tile_binner_flush_state,
    input wire tile_binner_oom,
    input wire tile_binner_overspill,
    output reg [1:0] bin_vertex_mode,
    output reg [1:0] ren_vertex_mode,
    input wire [1:0] batch_req,
    input wire [1:0] batch_done,
    output wire [1:0] batch_grant,
    output wire [1:0] xy_pass,
    output reg [31:0] shader_reservation,
    input wire scoreboard_idle,
    output reg cov_select,
    output reg host_irq
);
    reg [7:0] aw_addr;
    reg aw_got;
    reg [31:0] w_data;
    reg [3:0] w_strb;
    reg w_got;
    reg [7:0] mk0;
    reg [7:0] mk1;
    reg [31:0] bfc;
    reg [31:0] rfc;
    reg [`IRQ_W-1:0] int_en;
    reg [`IRQ_W-1:0] int_st;
    reg [7:0] sem;
    reg cov_req;
    reg [31:0] rd_data;
    reg rd_ok;
    reg wr_ok;
    reg [`IRQ_W-1:0] next_int_st;
    reg [7:0] next_sem;
    wire wr_fire;
    wire [31:0] cur0;
    wire [31:0] cur1;
    wire [31:0] end0;
    wire [31:0] end1;
    wire v0;
    wire v1;
    wire [7:0] op0;
    wire [7:0] op1;
    wire [31:0] arg0;
    wire [31:0] arg1;
    wire semw0;
    wire semw1;
    wire run0;
    wire run1;
    wire take0;
    wire take1;
    wire bin_frame;
    wire ren_frame;
    wire [`IRQ_W-1:0] events;

    function [31:0] merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0] strb;
        integer i;
        begin
            merge = old;
            for (i = 0; i < 4; i = i + 1) begin
                if (strb[i]) begin
                    merge[8*i +: 8] = nw[8*i +: 8];
                end
            end
        end
    endfunction

    function [1:0] mode_of;
        input [7:0] op;
        input [1:0] old;
        begin
            case (op)
                `OP_SH_GL: mode_of = `VM_SHADED;
                `OP_SH_NV: mode_of = `VM_PRESHADED;
                `OP_SH_VG: mode_of = `VM_XY;
                default: mode_of = old;
            endcase
        end
    endfunction

    assign wr_fire = aw_got && w_got && !bvalid;

    // Thread 0 only ever runs the binning list, thread 1 the rendering list.
    list_fetcher bin_thread (
        .clk(clk),
        .srst(srst),
        .cur_wr(wr_fire && (aw_addr == `REG_CT0_CUR)),
        .end_wr(wr_fire && (aw_addr == `REG_CT0_END)),
        .wdata(merge(aw_addr == `REG_CT0_CUR ? cur0 : end0, w_data, w_strb)),
        .sem_grant(take0),
        .cur_addr(cur0),
        .end_addr(end0),
        .fetch_req(bin_fetch_req),
        .fetch_addr(bin_fetch_addr),
        .fetch_valid(bin_fetch_valid),
        .fetch_data(bin_fetch_data),
        .cmd_valid(v0),
        .cmd_op(op0),
        .cmd_arg(arg0),
        .sem_wait(semw0),
        .running(run0)
    );

    list_fetcher ren_thread (
        .clk(clk),
        .srst(srst),
        .cur_wr(wr_fire && (aw_addr == `REG_CT1_CUR)),
        .end_wr(wr_fire && (aw_addr == `REG_CT1_END)),
        .wdata(merge(aw_addr == `REG_CT1_CUR ? cur1 : end1, w_data, w_strb)),
        .sem_grant(take1),
        .cur_addr(cur1),
        .end_addr(end1),
        .fetch_req(ren_fetch_req),
        .fetch_addr(ren_fetch_addr),
        .fetch_valid(ren_fetch_valid),
        .fetch_data(ren_fetch_data),
        .cmd_valid(v1),
        .cmd_op(op1),
        .cmd_arg(arg1),
        .sem_wait(semw1),
        .running(run1)
    );

    batch_arbiter vertex_share (
        .clk(clk),
        .srst(srst),
        .batch_req(batch_req),
        .batch_done(batch_done),
        .bin_mode(bin_vertex_mode),
        .ren_mode(ren_vertex_mode),
        .batch_grant(batch_grant),
        .xy_pass(xy_pass)
    );

    // Binning waits take priority when both threads wait on a single count.
    assign take0 = semw0 && (sem != 8'h0);
    assign take1 = semw1 && (sem > {7'h0, take0});
    assign bin_frame = v0 && ((op0 == `OP_FLUSH) || (op0 == `OP_FLUSH_ALL));
    assign ren_frame = v1 && (op1 == `OP_STORE_EOF);
    assign events = {tile_binner_overspill, tile_binner_oom, bin_frame, ren_frame};

    always @* begin
        next_sem = sem + {7'h0, v0 && (op0 == `OP_SEM_INC)} + {7'h0, v1 && (op1 == `OP_SEM_INC)};
        next_sem = next_sem - {7'h0, take0} - {7'h0, take1};
    end

    always @* begin
        next_int_st = int_st;
        if (wr_fire && (aw_addr == `REG_INT_ST)) begin
            next_int_st = int_st & ~w_data[`IRQ_W-1:0];
        end
        next_int_st = next_int_st | events;
    end

    always @* begin
        rd_data = 32'h0;
        rd_ok = 1'b1;
        case (araddr)
            `REG_CT0_CUR: rd_data = cur0;
            `REG_CT1_CUR: rd_data = cur1;
            `REG_CT0_END: rd_data = end0;
            `REG_CT1_END: rd_data = end1;
            `REG_CT0_CS: begin
                rd_data[`CS_MK_MSB:0] = mk0;
                rd_data[`CS_RUN] = run0;
                rd_data[`CS_SEMW] = semw0;
            end
            `REG_CT1_CS: begin
                rd_data[`CS_MK_MSB:0] = mk1;
                rd_data[`CS_RUN] = run1;
                rd_data[`CS_SEMW] = semw1;
            end
            `REG_BFC: rd_data = bfc;
            `REG_RFC: rd_data = rfc;
            `REG_INT_EN: rd_data[`IRQ_W-1:0] = int_en;
            `REG_INT_ST: rd_data[`IRQ_W-1:0] = int_st;
            `REG_QRSV: rd_data = shader_reservation;
            `REG_PIPE_ST: begin
                rd_data[`PS_BMODE] = bin_vertex_mode;
                rd_data[`PS_RMODE] = ren_vertex_mode;
                rd_data[`PS_COV] = cov_select;
                rd_data[`PS_SEM] = sem;
            end
            default: rd_ok = 1'b0;
        endcase
    end

    always @* begin
        case (aw_addr)
            `REG_CT0_CUR, `REG_CT1_CUR, `REG_CT0_END, `REG_CT1_END: wr_ok = 1'b1;
            `REG_CT0_CS, `REG_CT1_CS, `REG_BFC, `REG_RFC: wr_ok = 1'b1;
            `REG_INT_EN, `REG_INT_ST, `REG_QRSV, `REG_PIPE_ST: wr_ok = 1'b1;
            default: wr_ok = 1'b0;
        endcase
    end

    // Register bus slave; address and data may arrive in either order.
    always @(posedge clk) begin
        if (srst) begin
            awready <= 1'b1;
            wready <= 1'b1;
            arready <= 1'b1;
            aw_got <= 1'b0;
            w_got <= 1'b0;
            aw_addr <= 8'h0;
            w_data <= 32'h0;
            w_strb <= 4'h0;
            bvalid <= 1'b0;
            bresp <= `RESP_OKAY;
            rvalid <= 1'b0;
            rresp <= `RESP_OKAY;
            rdata <= 32'h0;
        end else begin
            if (awvalid && awready) begin
                aw_addr <= awaddr;
                aw_got <= 1'b1;
                awready <= 1'b0;
            end
            if (wvalid && wready) begin
                w_data <= wdata;
                w_strb <= wstrb;
                w_got <= 1'b1;
                wready <= 1'b0;
            end
            if (wr_fire) begin
                aw_got <= 1'b0;
                w_got <= 1'b0;
                bvalid <= 1'b1;
                bresp <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
            end
            if (bvalid && bready) begin
                bvalid <= 1'b0;
                awready <= 1'b1;
                wready <= 1'b1;
            end
            if (arvalid && arready) begin
                arready <= 1'b0;
                rvalid <= 1'b1;
                rdata <= rd_data;
                rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
            end
            if (rvalid && rready) begin
                rvalid <= 1'b0;
                arready <= 1'b1;
            end
        end
    end

    // Command side effects, counters and configuration registers.
    always @(posedge clk) begin
        if (srst) begin
            mk0 <= 8'h0;
            mk1 <= 8'h0;
            bfc <= 32'h0;
            rfc <= 32'h0;
            int_en <= {`IRQ_W{1'b0}};
            int_st <= {`IRQ_W{1'b0}};
            host_irq <= 1'b0;
            sem <= 8'h0;
            tile_binner_start <= 1'b0;
            tile_binner_flush <= 1'b0;
            tile_binner_flush_state <= 1'b0;
            bin_vertex_mode <= `VM_SHADED;
            ren_vertex_mode <= `VM_SHADED;
            shader_reservation <= 32'h0;
            cov_req <= 1'b0;
            cov_select <= 1'b0;
        end else begin
            if (v0 && (op0 == `OP_MARKER)) begin
                mk0 <= mk0 + 8'h1;
            end
            if (v1 && (op1 == `OP_MARKER)) begin
                mk1 <= mk1 + 8'h1;
            end
            if (bin_frame) begin
                bfc <= bfc + 32'h1;
            end
            if (ren_frame) begin
                rfc <= rfc + 32'h1;
            end
            sem <= next_sem;
            // Binner controls come from the binning thread only.
            tile_binner_start <= v0 && (op0 == `OP_START_BIN);
            tile_binner_flush <= bin_frame;
            tile_binner_flush_state <= v0 && (op0 == `OP_FLUSH_ALL);
            // Modes change in list order, so later primitives see the new mode only.
            if (v0) begin
                bin_vertex_mode <= mode_of(op0, bin_vertex_mode);
            end
            if (v1) begin
                ren_vertex_mode <= mode_of(op1, ren_vertex_mode);
            end
            if (v1 && (op1 == `OP_CONFIG)) begin
                cov_req <= arg1[`CFG_COV_BIT];
            end
            // Switching fragment paths only at an idle scoreboard keeps pixel order.
            if (scoreboard_idle) begin
                cov_select <= cov_req;
            end
            if (wr_fire && (aw_addr == `REG_INT_EN)) begin
                int_en <= w_data[`IRQ_W-1:0];
            end
            if (wr_fire && (aw_addr == `REG_QRSV)) begin
                shader_reservation <= merge(shader_reservation, w_data, w_strb);
            end
            int_st <= next_int_st;
            host_irq <= |(next_int_st & int_en);
        end
    end
endmodule
`default_nettype wire

//--- dv/list_memory.sv
// Byte memory that answers command-list fetches after a set latency.
`timescale 1ns/1ps
`default_nettype none
module list_memory #(parameter int LAT = 0) (
    input wire logic clk,
    input wire logic req,
    input wire logic [31:0] addr,
    output logic valid,
    output logic [7:0] data
);
    logic [7:0] mem [0:15];
    int cnt = 0;
    initial {valid, data} = 9'h000;
    // Idle data toggles so that a sample outside the answer never looks valid.
    always @(posedge clk) begin
        valid <= 1'b0;
        data <= ~data;
        if (req && !valid) begin
            if (cnt == LAT) begin
                valid <= 1'b1;
                data <= mem[addr[3:0]];
                cnt <= 0;
            end else begin
                cnt <= cnt + 1;
            end
        end
    end
endmodule
`default_nettype wire

//--- dv/cle_checker.sv
// Port assertions for the list executer.
`timescale 1ns/1ps
`default_nettype none
`include "cle_defines.vh"
module cle_checker (
    input wire clk,
    input wire srst,
    input wire awvalid,
    input wire awready,
    input wire wvalid,
    input wire wready,
    input wire bvalid,
    input wire arvalid,
    input wire arready,
    input wire rvalid,
    input wire bin_fetch_req,
    input wire [31:0] bin_fetch_addr,
    input wire bin_fetch_valid,
    input wire ren_fetch_req,
    input wire ren_fetch_valid,
    input wire tile_binner_flush,
    input wire tile_binner_flush_state,
    input wire [1:0] bin_vertex_mode,
    input wire [1:0] batch_req,
    input wire [1:0] batch_done,
    input wire [1:0] batch_grant,
    input wire [1:0] xy_pass,
    input wire scoreboard_idle,
    input wire cov_select
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);
    sequence s_granted;
        batch_grant != 2'b00;
    endsequence
    sequence s_no_done;
        (batch_done == 2'b00) [*3];
    endsequence
    AST_ENGINE_BUSY: assert property (s_granted ##1 s_no_done |-> batch_grant == 2'b00)
        else $error("grant while engine busy");
    AST_GRANT_REQ: assert property ($onehot0(batch_grant) && !(batch_grant & ~$past(batch_req)))
        else $error("grant without request");
    AST_XY_LAG: assert property (xy_pass[0] |-> $past(bin_vertex_mode) == `VM_XY)
        else $error("xy pass without direct mode");
    AST_FLUSH_STATE: assert property (tile_binner_flush_state |-> tile_binner_flush)
        else $error("state flush without flush");
    AST_FETCH_HOLD: assert property (bin_fetch_req && !bin_fetch_valid |=> bin_fetch_req && $stable(bin_fetch_addr))
        else $error("fetch request not held");
    AST_FETCH_GAP: assert property (ren_fetch_valid |=> !ren_fetch_req)
        else $error("fetch request too soon");
    AST_WR_RESP: assert property (awvalid && awready && wvalid && wready |=> !awready ##1 bvalid)
        else $error("write response late");
    AST_RD_RESP: assert property (arvalid && arready |=> rvalid && !arready)
        else $error("read response late");
    AST_COV_IDLE: assert property ($changed(cov_select) |-> $past(scoreboard_idle))
        else $error("coverage select changed while busy");
endmodule
bind tile_control_list_executer cle_checker chk_i (.*);
`default_nettype wire

//--- dv/testbench.sv
// Register-level test of the list executer with two list memories.
`timescale 1ns/1ps
`default_nettype none
`include "cle_defines.vh"
module testbench;
    logic clk = 1'b0, srst = 1'b1, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, tile_binner_oom = 1'b0, tile_binner_overspill = 1'b0;
    logic scoreboard_idle = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rd_data;
    logic [3:0] wstrb = 4'hF;
    logic [1:0] batch_req = 2'h0, batch_done = 2'h0, g, rd_resp;
    wire awready, wready, bvalid, arready, rvalid, bin_fetch_req, bin_fetch_valid;
    wire ren_fetch_req, ren_fetch_valid, tile_binner_start, tile_binner_flush;
    wire tile_binner_flush_state, cov_select, host_irq;
    wire [1:0] bresp, rresp, bin_vertex_mode, ren_vertex_mode, batch_grant, xy_pass;
    wire [31:0] rdata, bin_fetch_addr, ren_fetch_addr, shader_reservation;
    wire [7:0] bin_fetch_data, ren_fetch_data;
    int n_errors = 0, comparisons = 0, n_start = 0, n_flush = 0, n_fstate = 0;
    // Binning list ends part one with a flush and a semaphore increment, part two with a flush; the render list waits first.
    logic [7:0] bp [16] = '{8'h02, 8'h02, 8'h06, 8'h42, 8'h00, 8'h00, 8'h00, 8'h00, 8'h04,
        8'h07, 8'h40, 8'h00, 8'h00, 8'h00, 8'h00, 8'h05};
    logic [7:0] rp [9] = '{8'h08, 8'h41, 8'h00, 8'h00, 8'h00, 8'h00, 8'h60, 8'h01, 8'h19};
    always #5 clk = ~clk;
    always @(posedge clk) begin
        n_start <= n_start + tile_binner_start;
        n_flush <= n_flush + tile_binner_flush;
        n_fstate <= n_fstate + tile_binner_flush_state;
    end
    tile_control_list_executer uut (.*);
    list_memory #(.LAT(0)) mem_b (.clk, .req(bin_fetch_req), .addr(bin_fetch_addr),
        .valid(bin_fetch_valid), .data(bin_fetch_data));
    list_memory #(.LAT(3)) mem_r (.clk, .req(ren_fetch_req), .addr(ren_fetch_addr),
        .valid(ren_fetch_valid), .data(ren_fetch_data));
    task chk(input string nm, input [31:0] e, input [31:0] v);
        comparisons++;
        if (v !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, v);
        end
    endtask
    task wr(input [7:0] a, input [31:0] d);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        {awvalid, wvalid, bready} <= 3'b111;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        rd_resp = bresp;
        bready <= 1'b0;
    endtask
    task rd(input [7:0] a);
        @(posedge clk);
        araddr <= a;
        {arvalid, rready} <= 2'b11;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rd_data = rdata;
        rd_resp = rresp;
        rready <= 1'b0;
    endtask
    task rchk(input string nm, input [7:0] a, input [31:0] e);
        rd(a);
        chk(nm, e, rd_data);
    endtask
    task idle(input [7:0] a);
        do rd(a); while (rd_data[`CS_RUN] !== 1'b0);
    endtask
    task report_and_stop;
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        #300000;
        n_errors++;
        report_and_stop;
    end
    initial begin
        for (int i = 0; i < 16; i++) mem_b.mem[i] = bp[i];
        for (int i = 0; i < 9; i++) mem_r.mem[i] = rp[i];
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        wr(`REG_BFC, 32'h5);
        rchk("bfc_ro", `REG_BFC, 32'h0);
        wr(8'h30, 32'h1);
        chk("wr_unmap", `RESP_SLVERR, rd_resp);
        rd(8'h30);
        chk("unmapped", `RESP_SLVERR, rd_resp);
        wr(`REG_QRSV, 32'hA5A5_5A5A);
        chk("qrsv", 32'hA5A5_5A5A, shader_reservation);
        $display("register test done");
        wr(`REG_INT_EN, 32'h5);
        wr(`REG_CT1_CUR, 32'h0);
        wr(`REG_CT1_END, 32'h9);
        do rd(`REG_CT1_CS); while (rd_data[`CS_SEMW] !== 1'b1);
        chk("cs1_wait", 32'h300, rd_data);
        wr(`REG_CT0_CUR, 32'h0);
        wr(`REG_CT0_END, 32'hA);
        idle(`REG_CT0_CS);
        chk("markers", 32'h2, rd_data);
        rchk("bfc", `REG_BFC, 32'h1);
        rchk("cur0", `REG_CT0_CUR, 32'hA);
        chk("bin_mode", `VM_XY, bin_vertex_mode);
        chk("xy_pass", 2'b01, xy_pass);
        chk("starts", 1, n_start);
        idle(`REG_CT1_CS);
        chk("cs1", 32'h0, rd_data);
        chk("cov0", 0, cov_select);
        scoreboard_idle <= 1'b1;
        rchk("rfc", `REG_RFC, 32'h1);
        chk("ren_mode", `VM_PRESHADED, ren_vertex_mode);
        chk("cov", 1, cov_select);
        chk("irq", 1, host_irq);
        rchk("pipe", `REG_PIPE_ST, 32'h16);
        wr(`REG_INT_ST, 32'h1);
        rchk("ist", `REG_INT_ST, 32'h2);
        chk("irq_clr", 0, host_irq);
        $display("thread test done");
        wr(`REG_CT0_END, 32'h10);
        idle(`REG_CT0_CS);
        rchk("bfc2", `REG_BFC, 32'h2);
        chk("bin_mode0", `VM_SHADED, bin_vertex_mode);
        chk("fstate", 1, n_fstate);
        chk("flush", 2, n_flush);
        {tile_binner_oom, tile_binner_overspill} <= 2'b11;
        @(posedge clk);
        {tile_binner_oom, tile_binner_overspill} <= 2'b00;
        rchk("ist_ev", `REG_INT_ST, 32'hE);
        chk("irq_oom", 1, host_irq);
        wr(`REG_INT_ST, 32'hC);
        tile_binner_overspill <= 1'b1;
        @(posedge clk);
        tile_binner_overspill <= 1'b0;
        rchk("ist_ovsp", `REG_INT_ST, 32'hA);
        chk("irq_mask", 0, host_irq);
        $display("interrupt test done");
        batch_req <= 2'b11;
        do @(posedge clk); while (batch_grant === 2'b00);
        g = batch_grant;
        batch_done <= g;
        @(posedge clk);
        batch_done <= 2'b00;
        do @(posedge clk); while (batch_grant === 2'b00);
        chk("grant", g ^ 2'b11, batch_grant);
        $display("batch test done");
        report_and_stop;
    end
endmodule
`default_nettype wire
